// file: rtl/bte_pkg.sv
// Package of opcodes, field layouts and constants for the bit and transfer execution unit
package bte_pkg;
	localparam int DATA_W = 8;
	localparam int RF_N = 16;
	localparam int ADDR_W = 16;
	localparam int IOA_W = 6;
	// Status register bit positions
	localparam int SF_C = 0;
	localparam int SF_Z = 1;
	localparam int SF_N = 2;
	localparam int SF_V = 3;
	localparam int SF_S = 4;
	localparam int SF_H = 5;
	localparam int SF_T = 6;
	localparam int SF_I = 7;
	localparam logic [7:0] STATUS_RST = 8'h00;
	// Pointer pairs sit at the top of the register file, low byte first
	localparam logic [3:0] PTR_X_LO = 4'ha;
	// Register port map
	localparam logic [4:0] RA_RF_BASE = 5'h00;
	localparam logic [4:0] RA_STATUS = 5'h10;
	localparam logic [4:0] RA_SP = 5'h11;
	// Cycle counts of the instruction classes
	localparam int CYC_SHORT = 1;
	localparam int CYC_LONG = 2;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_LOGICAL_SHIFT_LEFT = 5'h01, OP_LOGICAL_SHIFT_RIGHT = 5'h02,
		OP_ROTATE_LEFT_THROUGH_CARRY = 5'h03, OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h04,
		OP_ARITH_SHIFT_RIGHT = 5'h05, OP_SWAP = 5'h06, OP_FSET = 5'h07,
		OP_FCLR = 5'h08, OP_IOSET = 5'h09, OP_IOCLR = 5'h0a, OP_BIT_TO_T_FLAG_COPY = 5'h0b,
		OP_T_FLAG_TO_BIT_COPY = 5'h0c, OP_MOV = 5'h0d, OP_LDI = 5'h0e, OP_LDIND = 5'h0f,
		OP_STIND = 5'h10, OP_LDDIR = 5'h11, OP_STDIR = 5'h12, OP_IN = 5'h13,
		OP_OUT = 5'h14, OP_PUSH = 5'h15, OP_POP = 5'h16, OP_SLEEP = 5'h17,
		OP_WATCHDOG_KICK = 5'h18, OP_BREAK = 5'h19
	} bte_op_t;

	typedef enum logic [1:0] {
		PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2
	} bte_ptr_t;

	typedef enum logic [1:0] {
		PM_PLAIN = 2'h0, PM_POSTINC = 2'h1, PM_PREDEC = 2'h2
	} bte_pmode_t;

	typedef struct packed {
		bte_op_t op;
		logic [3:0] rd;
		logic [3:0] rr;
		logic [2:0] bitn;
		bte_ptr_t ptr;
		bte_pmode_t pmode;
		logic [IOA_W-1:0] io_addr;
		logic [ADDR_W-1:0] k;
	} bte_ins_t;

	typedef struct packed {
		logic re;
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bte_dm_req_t;

	typedef struct packed {
		logic re;
		logic we;
		logic flag_set_by_index;
		logic flag_clear_by_index;
		logic [2:0] bitn;
		logic [IOA_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bte_io_req_t;
endpackage

// file: rtl/bte_shift.sv
// Shift, rotate and nibble swap unit with flag results and update mask
`timescale 1ns/1ns
module bte_shift (
	input wire bte_pkg::bte_op_t i_op,
	input wire logic [7:0] i_val,
	input wire logic i_carry,
	output logic [7:0] o_res,
	output logic [7:0] o_flags,
	output logic [7:0] o_mask
);
	import bte_pkg::*;

	logic c;
	logic n;
	logic v;

	always_comb begin
		o_res = i_val;
		c = 1'b0;
		o_mask = 8'h00;
		unique case (i_op)
			OP_LOGICAL_SHIFT_LEFT: begin
				o_res = {i_val[6:0], 1'b0};
				c = i_val[7];
				o_mask = 8'h2f;
			end
			OP_LOGICAL_SHIFT_RIGHT: begin
				o_res = {1'b0, i_val[7:1]};
				c = i_val[0];
				o_mask = 8'h0f;
			end
			OP_ROTATE_LEFT_THROUGH_CARRY: begin
				o_res = {i_val[6:0], i_carry};
				c = i_val[7];
				o_mask = 8'h1f;
			end
			OP_ROTATE_RIGHT_THROUGH_CARRY: begin
				o_res = {i_carry, i_val[7:1]};
				c = i_val[0];
				o_mask = 8'h0f;
			end
			OP_ARITH_SHIFT_RIGHT: begin
				o_res = {i_val[7], i_val[7:1]};
				c = i_val[0];
				o_mask = 8'h0f;
			end
			OP_SWAP: begin
				o_res = {i_val[3:0], i_val[7:4]};
			end
			default: begin
				o_res = i_val;
			end
		endcase
		n = o_res[7];
		v = n ^ c;
		o_flags = 8'h00;
		o_flags[SF_C] = c;
		o_flags[SF_Z] = (o_res == 8'h00);
		o_flags[SF_N] = n;
		o_flags[SF_V] = v;
		o_flags[SF_S] = n ^ v;
		// Half carry of a left shift is the old bit 3
		o_flags[SF_H] = i_val[3];
	end
endmodule

// file: rtl/bte_exec.sv
// Execution unit for bit, flag, data transfer and control instructions
`timescale 1ns/1ns
module bte_exec #(
	parameter int SP_W = 8,
	parameter logic [15:0] SP_RST = 16'h00ff
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ins_valid,
	input wire bte_pkg::bte_ins_t i_ins,
	output logic o_ins_ready,
	output bte_pkg::bte_dm_req_t o_dm_req,
	input wire logic [7:0] i_dm_rdata,
	output bte_pkg::bte_io_req_t o_io_req,
	input wire logic [7:0] i_io_rdata,
	output logic o_sleep,
	output logic o_wdt_kick,
	output logic o_break,
	output logic [7:0] o_status,
	input wire logic [4:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata
);
	import bte_pkg::*;

	// A stack pointer wider than the data address cannot be served
	if (SP_W < 1 || SP_W > ADDR_W) begin : g_sp_w_check
		$error("SP_W out of range");
	end

	logic [7:0] rf_ff [RF_N];
	logic [7:0] status_ff;
	logic [SP_W-1:0] sp_ff;
	logic ready_ff;
	logic wb_pend_ff;
	logic wb_io_ff;
	logic [3:0] wb_idx_ff;
	bte_dm_req_t dm_ff;
	bte_io_req_t io_ff;
	logic sleep_ff;
	logic wdt_ff;
	logic brk_ff;
	logic [7:0] reg_rdata_ff;

	logic take;
	logic [7:0] wb_data;
	logic [7:0] rd_val;
	logic [7:0] rr_val;
	logic [3:0] ptr_lo;
	logic [15:0] ptr_old;
	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;
	logic [7:0] sh_res;
	logic [7:0] sh_flags;
	logic [7:0] sh_mask;
	logic [15:0] sp_ext;
	logic [15:0] sp_up;

	logic nxt_ready;
	logic nxt_ex_we;
	logic [7:0] nxt_ex_wd;
	logic nxt_ptr_we;
	logic [15:0] nxt_ptr;
	logic [7:0] nxt_status;
	logic [SP_W-1:0] nxt_sp;
	logic nxt_wb_pend;
	logic nxt_wb_io;
	bte_dm_req_t nxt_dm;
	bte_io_req_t nxt_io;

	assign take = i_ins_valid && ready_ff;
	assign wb_data = wb_io_ff ? i_io_rdata : i_dm_rdata;

	// Forward a load result still in flight so the next instruction sees it
	function automatic logic [7:0] opnd(input logic [3:0] idx);
		logic [7:0] val;
		val = rf_ff[idx];
		if (wb_pend_ff && wb_idx_ff == idx) begin
			val = wb_data;
		end
		return val;
	endfunction

	assign rd_val = opnd(i_ins.rd);
	assign rr_val = opnd(i_ins.rr);
	assign ptr_lo = PTR_X_LO + {1'b0, i_ins.ptr, 1'b0};
	assign ptr_old = {opnd(ptr_lo + 4'h1), opnd(ptr_lo)};
	assign ptr_inc = ptr_old + 16'h0001;
	assign ptr_dec = ptr_old - 16'h0001;
	assign sp_ext = 16'(sp_ff);
	assign sp_up = 16'(SP_W'(sp_ff + 1'b1));

	bte_shift u_shift (
		.i_op(i_ins.op),
		.i_val(rd_val),
		.i_carry(status_ff[SF_C]),
		.o_res(sh_res),
		.o_flags(sh_flags),
		.o_mask(sh_mask)
	);

	always_comb begin
		nxt_ready = 1'b1;
		nxt_ex_we = 1'b0;
		nxt_ex_wd = rd_val;
		nxt_ptr_we = 1'b0;
		nxt_ptr = ptr_old;
		nxt_status = status_ff;
		nxt_sp = sp_ff;
		nxt_wb_pend = 1'b0;
		nxt_wb_io = 1'b0;
		nxt_dm = '0;
		nxt_io = '0;
		if (take) begin
			unique case (i_ins.op)
				OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT, OP_ROTATE_LEFT_THROUGH_CARRY,
				OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ARITH_SHIFT_RIGHT, OP_SWAP: begin
					nxt_ex_we = 1'b1;
					nxt_ex_wd = sh_res;
					nxt_status = (status_ff & ~sh_mask) | (sh_flags & sh_mask);
				end
				OP_FSET: begin
					nxt_status[i_ins.bitn] = 1'b1;
				end
				OP_FCLR: begin
					nxt_status[i_ins.bitn] = 1'b0;
				end
				OP_IOSET, OP_IOCLR: begin
					nxt_io.flag_set_by_index = (i_ins.op == OP_IOSET);
					nxt_io.flag_clear_by_index = (i_ins.op == OP_IOCLR);
					nxt_io.bitn = i_ins.bitn;
					nxt_io.addr = i_ins.io_addr;
				end
				OP_BIT_TO_T_FLAG_COPY: begin
					nxt_status[SF_T] = rr_val[i_ins.bitn];
				end
				OP_T_FLAG_TO_BIT_COPY: begin
					nxt_ex_we = 1'b1;
					nxt_ex_wd[i_ins.bitn] = status_ff[SF_T];
				end
				OP_MOV: begin
					nxt_ex_we = 1'b1;
					nxt_ex_wd = rr_val;
				end
				OP_LDI: begin
					nxt_ex_we = 1'b1;
					nxt_ex_wd = i_ins.k[7:0];
				end
				OP_LDIND, OP_STIND: begin
					nxt_dm.re = (i_ins.op == OP_LDIND);
					nxt_dm.we = (i_ins.op == OP_STIND);
					nxt_dm.addr = (i_ins.pmode == PM_PREDEC) ? ptr_dec : ptr_old;
					nxt_dm.wdata = rr_val;
					nxt_wb_pend = (i_ins.op == OP_LDIND);
					nxt_ptr_we = (i_ins.pmode != PM_PLAIN);
					nxt_ptr = (i_ins.pmode == PM_PREDEC) ? ptr_dec : ptr_inc;
					nxt_ready = (i_ins.op == OP_LDIND) && (i_ins.pmode == PM_PLAIN) && (i_ins.ptr == PTR_X);
				end
				OP_LDDIR, OP_STDIR: begin
					nxt_dm.re = (i_ins.op == OP_LDDIR);
					nxt_dm.we = (i_ins.op == OP_STDIR);
					nxt_dm.addr = i_ins.k;
					nxt_dm.wdata = rr_val;
					nxt_wb_pend = (i_ins.op == OP_LDDIR);
					nxt_ready = 1'b0;
				end
				OP_IN: begin
					nxt_io.re = 1'b1;
					nxt_io.addr = i_ins.io_addr;
					nxt_wb_pend = 1'b1;
					nxt_wb_io = 1'b1;
				end
				OP_OUT: begin
					nxt_io.we = 1'b1;
					nxt_io.addr = i_ins.io_addr;
					nxt_io.wdata = rr_val;
				end
				OP_PUSH: begin
					nxt_dm.we = 1'b1;
					nxt_dm.addr = sp_ext;
					nxt_dm.wdata = rr_val;
					nxt_sp = SP_W'(sp_ff - 1'b1);
					nxt_ready = 1'b0;
				end
				OP_POP: begin
					nxt_dm.re = 1'b1;
					nxt_dm.addr = sp_up;
					nxt_sp = SP_W'(sp_ff + 1'b1);
					nxt_wb_pend = 1'b1;
					nxt_ready = 1'b0;
				end
				OP_NOP, OP_SLEEP, OP_WATCHDOG_KICK, OP_BREAK: begin
					nxt_ready = 1'b1;
				end
				default: begin
					nxt_ready = 1'b1;
				end
			endcase
		end
	end

	// Register file: port write first, then load return, then the issuing instruction
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < RF_N; i++) begin
				rf_ff[i] <= 8'h00;
			end
		end else begin
			if (i_reg_wr && i_reg_addr[4] == 1'b0) begin
				rf_ff[i_reg_addr[3:0]] <= i_reg_wdata;
			end
			if (wb_pend_ff) begin
				rf_ff[wb_idx_ff] <= wb_data;
			end
			if (nxt_ptr_we) begin
				rf_ff[ptr_lo] <= nxt_ptr[7:0];
				rf_ff[ptr_lo + 4'h1] <= nxt_ptr[15:8];
			end
			if (nxt_ex_we) begin
				rf_ff[i_ins.rd] <= nxt_ex_wd;
			end
		end
	end

	// Status flags; an instruction's update overrides a same-cycle port write
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			status_ff <= STATUS_RST;
		end else if (take) begin
			status_ff <= nxt_status;
		end else if (i_reg_wr && i_reg_addr == RA_STATUS) begin
			status_ff <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sp_ff <= SP_W'(SP_RST);
		end else if (take) begin
			sp_ff <= nxt_sp;
		end else if (i_reg_wr && i_reg_addr == RA_SP) begin
			sp_ff <= SP_W'(i_reg_wdata);
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			ready_ff <= 1'b1;
		end else begin
			ready_ff <= nxt_ready;
		end
	end

	// Memory and I/O strobes last one cycle; read data return in that cycle
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			dm_ff <= '0;
			io_ff <= '0;
			wb_pend_ff <= 1'b0;
			wb_io_ff <= 1'b0;
			wb_idx_ff <= 4'h0;
		end else begin
			dm_ff <= nxt_dm;
			io_ff <= nxt_io;
			wb_pend_ff <= nxt_wb_pend;
			wb_io_ff <= nxt_wb_io;
			wb_idx_ff <= i_ins.rd;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			sleep_ff <= 1'b0;
			wdt_ff <= 1'b0;
			brk_ff <= 1'b0;
		end else begin
			sleep_ff <= take && i_ins.op == OP_SLEEP;
			wdt_ff <= take && i_ins.op == OP_WATCHDOG_KICK;
			brk_ff <= take && i_ins.op == OP_BREAK;
		end
	end

	// Port reads see committed state only; in-flight loads are not visible yet
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			reg_rdata_ff <= 8'h00;
		end else if (i_reg_rd) begin
			if (i_reg_addr[4] == 1'b0) begin
				reg_rdata_ff <= rf_ff[i_reg_addr[3:0]];
			end else if (i_reg_addr == RA_STATUS) begin
				reg_rdata_ff <= status_ff;
			end else if (i_reg_addr == RA_SP) begin
				reg_rdata_ff <= sp_ext[7:0];
			end else begin
				reg_rdata_ff <= 8'h00;
			end
		end
	end

	assign o_ins_ready = ready_ff;
	assign o_dm_req = dm_ff;
	assign o_io_req = io_ff;
	assign o_sleep = sleep_ff;
	assign o_wdt_kick = wdt_ff;
	assign o_break = brk_ff;
	assign o_status = status_ff;
	assign o_reg_rdata = reg_rdata_ff;
endmodule

// file: test/bte_exec_assertions.sv
// Concurrent checks on the ports of the bit and transfer execution unit
`timescale 1ns/1ns
module bte_exec_assertions (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ins_valid,
	input wire bte_pkg::bte_ins_t i_ins,
	input wire logic o_ins_ready,
	input wire bte_pkg::bte_dm_req_t o_dm_req,
	input wire bte_pkg::bte_io_req_t o_io_req,
	input wire logic o_sleep,
	input wire logic o_wdt_kick,
	input wire logic o_break,
	input wire logic [7:0] o_status
);
	import bte_pkg::*;
	logic tk;
	logic lng;
	assign tk = i_ins_valid && o_ins_ready;
	assign lng = tk && (i_ins.op inside {OP_STIND, OP_LDDIR, OP_STDIR, OP_PUSH, OP_POP}
		|| (i_ins.op == OP_LDIND && !(i_ins.ptr == PTR_X && i_ins.pmode == PM_PLAIN)));
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);
	sequence s_hold;
		!o_ins_ready ##1 o_ins_ready;
	endsequence
	a_long_stall: assert property (lng |=> s_hold) else $error("long op stall wrong");
	a_short_ready: assert property (tk && !lng |=> o_ins_ready) else $error("short op stalled");
	a_direct_read: assert property (tk && i_ins.op == OP_LDDIR |=> o_dm_req.re
		&& o_dm_req.addr == $past(i_ins.k)) else $error("direct read wrong");
	a_direct_write: assert property (tk && i_ins.op == OP_STDIR |=> o_dm_req.we
		&& o_dm_req.addr == $past(i_ins.k)) else $error("direct write wrong");
	a_io_bit: assert property (tk && i_ins.op inside {OP_IOSET, OP_IOCLR}
		|=> o_io_req.flag_set_by_index == $past(i_ins.op == OP_IOSET)
		&& o_io_req.flag_clear_by_index == $past(i_ins.op == OP_IOCLR) && o_io_req.addr == $past(i_ins.io_addr)
		&& o_io_req.bitn == $past(i_ins.bitn)) else $error("io bit op wrong");
	a_flags_kept: assert property (tk
		&& i_ins.op inside {OP_IOSET, OP_IOCLR, OP_IN, OP_OUT, OP_T_FLAG_TO_BIT_COPY, OP_PUSH, OP_POP,
		OP_LDDIR, OP_STDIR, OP_LDIND, OP_STIND, OP_SLEEP, OP_WATCHDOG_KICK}
		|=> $stable(o_status)) else $error("flags changed");
	a_flag_set: assert property (tk && i_ins.op == OP_FSET
		|=> o_status == ($past(o_status) | (8'h01 << $past(i_ins.bitn)))) else $error("flag set wrong");
	a_flag_clear: assert property (tk && i_ins.op == OP_FCLR
		|=> o_status == ($past(o_status) & ~(8'h01 << $past(i_ins.bitn)))) else $error("flag clear wrong");
	a_tcopy_only: assert property (tk && i_ins.op == OP_BIT_TO_T_FLAG_COPY
		|=> ((o_status ^ $past(o_status)) & 8'hbf) == 8'h00) else $error("bit store touched flags");
	a_sleep_pulse: assert property (tk && i_ins.op == OP_SLEEP
		|=> o_sleep ##1 !o_sleep) else $error("sleep pulse wrong");
	a_wdt_pulse: assert property (tk && i_ins.op == OP_WATCHDOG_KICK
		|=> o_wdt_kick ##1 !o_wdt_kick) else $error("kick wrong");
	a_break_flag: assert property (tk && i_ins.op == OP_BREAK
		|=> o_break && $stable(o_status)) else $error("break wrong");
endmodule

// file: test/bte_mem_model.sv
// Behavioural data memory and I/O space on the far side of the unit
`timescale 1ns/1ns
module bte_mem_model (
	input wire logic i_mclk,
	input wire bte_pkg::bte_dm_req_t i_dm_req,
	input wire bte_pkg::bte_io_req_t i_io_req,
	output logic [7:0] o_dm_rdata,
	output logic [7:0] o_io_rdata
);
	import bte_pkg::*;
	// Only 256 bytes: upper address bits alias
	logic [7:0] mem [256];
	logic [7:0] io [64];
	logic flip = 1'b0;
	// Idle read lines toggle so a stale sample never matches
	always @(posedge i_mclk) begin
		flip <= ~flip;
	end
	assign o_dm_rdata = i_dm_req.re ? mem[i_dm_req.addr[7:0]] : {8{flip}};
	assign o_io_rdata = i_io_req.re ? io[i_io_req.addr] : {8{~flip}};
	always @(posedge i_mclk) begin
		if (i_dm_req.we) begin
			mem[i_dm_req.addr[7:0]] <= i_dm_req.wdata;
		end
		if (i_io_req.we) begin
			io[i_io_req.addr] <= i_io_req.wdata;
		end
		if (i_io_req.flag_set_by_index) begin
			io[i_io_req.addr][i_io_req.bitn] <= 1'b1;
		end
		if (i_io_req.flag_clear_by_index) begin
			io[i_io_req.addr][i_io_req.bitn] <= 1'b0;
		end
	end
endmodule

// file: test/bte_exec_bench.sv
// Self-checking bench for the bit and transfer execution unit
`timescale 1ns/1ns
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("wrong value at %0t: got %h expected %h", $time, g, e); \
	end \
end
module bte_exec_bench;
	import bte_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic ins_valid = 1'b0;
	bte_ins_t ins = '0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ins_ready;
	bte_dm_req_t dm_req;
	bte_io_req_t io_req;
	logic [7:0] dm_rdata, io_rdata, status, reg_rdata;
	logic sleep_p, wdt_p, brk_p;
	int failures = 0;
	int total_checks = 0;
	always #20 i_mclk = ~i_mclk;
	bte_exec DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ins_valid(ins_valid), .i_ins(ins), .o_ins_ready(ins_ready),
		.o_dm_req(dm_req), .i_dm_rdata(dm_rdata), .o_io_req(io_req), .i_io_rdata(io_rdata), .o_sleep(sleep_p),
		.o_wdt_kick(wdt_p), .o_break(brk_p), .o_status(status), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));
	bte_mem_model MEM (.i_mclk(i_mclk), .i_dm_req(dm_req), .i_io_req(io_req), .o_dm_rdata(dm_rdata),
		.o_io_rdata(io_rdata));
	function automatic bte_ins_t mk(input bte_op_t op, input logic [3:0] d, input logic [3:0] s, input logic [2:0] b,
		input bte_ptr_t p = PTR_X, input bte_pmode_t m = PM_PLAIN, input logic [15:0] k = 16'h0000);
		mk = '0;
		mk.op = op;
		mk.rd = d;
		mk.rr = s;
		mk.bitn = b;
		mk.ptr = p;
		mk.pmode = m;
		mk.k = k;
		mk.io_addr = k[5:0];
	endfunction
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge i_mclk);
		reg_wr <= 1'b0;
		@(posedge i_mclk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge i_mclk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
		@(posedge i_mclk);
	endtask
	// Two trailing edges cover the longest op before the next issue
	task automatic run(input bte_ins_t t);
		ins <= t;
		ins_valid <= 1'b1;
		@(posedge i_mclk);
		ins_valid <= 1'b0;
		repeat (2) @(posedge i_mclk);
	endtask
	// Two one-cycle ops back to back; the second reads what the first loads
	task automatic run2(input bte_ins_t t1, input bte_ins_t t2);
		ins <= t1;
		ins_valid <= 1'b1;
		@(posedge i_mclk);
		ins <= t2;
		@(posedge i_mclk);
		ins_valid <= 1'b0;
		repeat (2) @(posedge i_mclk);
	endtask
	task automatic shift_row(input bte_op_t op, input logic [7:0] v, input logic c, input logic [7:0] r,
		input logic [7:0] f);
		wr(5'h01, v);
		wr(RA_STATUS, {7'h00, c});
		run(mk(op, 4'h1, 4'h0, 3'h0));
		rd(5'h01, r);
		rd(RA_STATUS, f);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		@(posedge i_mclk);
		rd(RA_STATUS, 8'h00);
		rd(RA_SP, 8'hff);
		for (int i = 0; i < 8; i++) begin
			run(mk(OP_FSET, 4'h0, 4'h0, 3'(i)));
			rd(RA_STATUS, 8'hff >> (7 - i));
		end
		for (int i = 0; i < 8; i++) begin
			run(mk(OP_FCLR, 4'h0, 4'h0, 3'(i)));
			rd(RA_STATUS, 8'hff << (i + 1));
		end
		$display("test flags done");
		shift_row(OP_LOGICAL_SHIFT_LEFT, 8'h88, 1'b0, 8'h10, 8'h29);
		shift_row(OP_LOGICAL_SHIFT_RIGHT, 8'h01, 1'b0, 8'h00, 8'h0b);
		shift_row(OP_ROTATE_LEFT_THROUGH_CARRY, 8'h80, 1'b1, 8'h01, 8'h19);
		shift_row(OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h02, 1'b1, 8'h81, 8'h0c);
		shift_row(OP_ARITH_SHIFT_RIGHT, 8'h81, 1'b0, 8'hc0, 8'h05);
		$display("test shifts done");
		wr(RA_STATUS, 8'h00);
		wr(5'h02, 8'h20);
		wr(5'h03, 8'h80);
		run(mk(OP_BIT_TO_T_FLAG_COPY, 4'h0, 4'h2, 3'h5));
		rd(RA_STATUS, 8'h40);
		run(mk(OP_T_FLAG_TO_BIT_COPY, 4'h3, 4'h0, 3'h0));
		rd(5'h03, 8'h81);
		$display("test tflag done");
		wr(5'h04, 8'h3c);
		run(mk(OP_STIND, 4'h0, 4'h4, 3'h0, PTR_Y, PM_PREDEC));
		rd(5'h0c, 8'hff);
		rd(5'h0d, 8'hff);
		`CHK(MEM.mem[8'hff], 8'h3c)
		run(mk(OP_LDIND, 4'h5, 4'h0, 3'h0, PTR_Y, PM_POSTINC));
		rd(5'h05, 8'h3c);
		rd(5'h0c, 8'h00);
		rd(5'h0d, 8'h00);
		run(mk(OP_STIND, 4'h0, 4'h3, 3'h0, PTR_Z, PM_POSTINC));
		`CHK(MEM.mem[8'h00], 8'h81)
		rd(5'h0e, 8'h01);
		run(mk(OP_LDIND, 4'h6, 4'h0, 3'h0, PTR_Z, PM_PREDEC));
		rd(5'h06, 8'h81);
		rd(5'h0e, 8'h00);
		run(mk(OP_STDIR, 4'h0, 4'h4, 3'h0, PTR_X, PM_PLAIN, 16'h0010));
		run(mk(OP_LDDIR, 4'h7, 4'h0, 3'h0, PTR_X, PM_PLAIN, 16'h0010));
		rd(5'h07, 8'h3c);
		wr(5'h0a, 8'h00);
		run(mk(OP_LDIND, 4'h8, 4'h0, 3'h0));
		rd(5'h08, 8'h81);
		run(mk(OP_LDIND, 4'h2, 4'h0, 3'h0, PTR_X, PM_POSTINC));
		rd(5'h02, 8'h81);
		rd(5'h0a, 8'h01);
		run(mk(OP_STIND, 4'h0, 4'h4, 3'h0, PTR_Y, PM_PLAIN));
		`CHK(MEM.mem[8'h00], 8'h3c)
		rd(5'h0c, 8'h00);
		run(mk(OP_LDIND, 4'h2, 4'h0, 3'h0, PTR_X, PM_PREDEC));
		rd(5'h02, 8'h3c);
		rd(5'h0a, 8'h00);
		run2(mk(OP_LDIND, 4'h8, 4'h0, 3'h0), mk(OP_MOV, 4'h1, 4'h8, 3'h0));
		rd(5'h01, 8'h3c);
		$display("test memory done");
		run(mk(OP_PUSH, 4'h0, 4'h3, 3'h0));
		`CHK(MEM.mem[8'hff], 8'h81)
		rd(RA_SP, 8'hfe);
		run(mk(OP_POP, 4'h9, 4'h0, 3'h0));
		rd(5'h09, 8'h81);
		rd(RA_SP, 8'hff);
		$display("test stack done");
		run(mk(OP_OUT, 4'h0, 4'h4, 3'h0, PTR_X, PM_PLAIN, 16'h0005));
		`CHK(MEM.io[5], 8'h3c)
		run(mk(OP_IOSET, 4'h0, 4'h0, 3'h0, PTR_X, PM_PLAIN, 16'h0005));
		run(mk(OP_IOCLR, 4'h0, 4'h0, 3'h2, PTR_X, PM_PLAIN, 16'h0005));
		run2(mk(OP_IN, 4'h1, 4'h0, 3'h0, PTR_X, PM_PLAIN, 16'h0005), mk(OP_MOV, 4'h2, 4'h1, 3'h0));
		rd(5'h01, 8'h39);
		rd(5'h02, 8'h39);
		run(mk(OP_SLEEP, 4'h0, 4'h0, 3'h0));
		run(mk(OP_WATCHDOG_KICK, 4'h0, 4'h0, 3'h0));
		run(mk(OP_BREAK, 4'h0, 4'h0, 3'h0));
		rd(RA_STATUS, 8'h40);
		$display("test io and control done");
		test_done();
	end
endmodule
bind bte_exec bte_exec_assertions chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ins_valid(i_ins_valid), .i_ins(i_ins),
	.o_ins_ready(o_ins_ready), .o_dm_req(o_dm_req), .o_io_req(o_io_req), .o_sleep(o_sleep), .o_wdt_kick(o_wdt_kick),
	.o_break(o_break), .o_status(o_status));
